// ---- src/bcr_consts.svh ----
// offsets, field positions and reset values of the board control register bank
`ifndef BCR_CONSTS_SVH
`define BCR_CONSTS_SVH

// ************************************************************
// register offsets
// ************************************************************
`define BCR_OFS_BOARD_ID     6'h00
`define BCR_OFS_BOARD_VER    6'h01
`define BCR_OFS_LOGIC_VER    6'h02
`define BCR_OFS_CTRL_STAT    6'h03
`define BCR_OFS_RESET_CTRL   6'h04
`define BCR_OFS_POWER_STAT   6'h05
`define BCR_OFS_AUX_ONE      6'h06
`define BCR_OFS_SPEED_SW     6'h07
`define BCR_OFS_AUX_TWO      6'h08
`define BCR_OFS_SEQ_CTRL     6'h10
`define BCR_OFS_SEQ_STAT     6'h11
`define BCR_OFS_SEQ_CFG0     6'h12
`define BCR_OFS_SEQ_CFG1     6'h13
`define BCR_OFS_CORE_VOLT    6'h14
`define BCR_OFS_BOOT_SET     6'h16
`define BCR_OFS_SPEED0       6'h17
`define BCR_OFS_SPEED1       6'h18
`define BCR_OFS_SPEED2       6'h19
`define BCR_OFS_SYSCLK0      6'h1c
`define BCR_OFS_SYSCLK1      6'h1d
`define BCR_OFS_SYSCLK2      6'h1e
`define BCR_OFS_MEMCLK0      6'h1f
`define BCR_OFS_MEMCLK1      6'h20
`define BCR_OFS_MEMCLK2      6'h21
`define BCR_OFS_WATCHDOG     6'h24
`define BCR_OFS_LAMPS        6'h25

// ************************************************************
// field positions, in big-endian bit numbers (bit 0 is the msb)
// ************************************************************
`define BCR_BIT_IDLE         1
`define BCR_BIT_ENDPOINT     3
`define BCR_BIT_ROUTE_HI     4
`define BCR_BIT_ROUTE_LO     5
`define BCR_BIT_PASS_OFF     6
`define BCR_BIT_FAIL_OFF     7

// ************************************************************
// reset values
// ************************************************************
`define BCR_RST_CTRL_STAT    8'h00
`define BCR_RST_PASS_OFF     1'b1
`define BCR_RST_FAIL_OFF     1'b0
`define BCR_RST_RESET_CTRL   8'h8f
`define BCR_RST_ZERO         8'h00
`define BCR_RST_WATCHDOG     8'h7f
`define BCR_RST_VARIES       8'h00
`define BCR_RESERVED_READ    8'h00

`endif

// ---- src/bcr_pkg.sv ----
// types shared by the board control register bank
package bcr_pkg;
  typedef enum logic [1:0] {
    BCR_ROUTE_DEBUG_IRQ,
    BCR_ROUTE_SOFT_RESET,
    BCR_ROUTE_USER_A,
    BCR_ROUTE_USER_B
  } bcr_route_t;

  typedef logic [7:0] bcr_byte_t;
endpackage

// ---- src/bcr_wr_if.sv ----
// write carrier between the bus decode and the storage registers
`timescale 1ns/1ns
interface bcr_wr_if;
  logic       we;
  logic [5:0] addr;
  logic [7:0] data;
  modport src (output we, output addr, output data);
  modport dst (input we, input addr, input data);
endinterface

// ---- src/bcr_store_reg.sv ----
// one byte-wide read/write storage register, written at its own offset
`timescale 1ns/1ns
module bcr_store_reg
  import bcr_pkg::*;
#(
  parameter logic [5:0] OFS       = 6'h00,
  parameter logic [7:0] RST_VALUE = 8'h00
)(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // write path
  bcr_wr_if.dst     wr,
  // stored value
  output bcr_byte_t value
);
  bcr_byte_t value_q;
  wire       hit = wr.we && (wr.addr == OFS);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      value_q <= RST_VALUE;
    else if (hit)
      value_q <= wr.data;
  end

  assign value = value_q;

  // ************************************************************
  // checks
  // ************************************************************
  store_write_a: assert property (@(posedge clk) disable iff (rst)
    hit |=> value == $past(wr.data))
    else $error("storage register missed a write");
  store_hold_a: assert property (@(posedge clk) disable iff (rst)
    !hit |=> $stable(value))
    else $error("storage register changed without a write");
endmodule

// ---- src/bcr_sync2.sv ----
// two-flop synchroniser for an input level from outside the clock domain
`timescale 1ns/1ns
module bcr_sync2 (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // level
  input  wire logic din,
  output logic      dout
);
  logic meta_q;
  logic sync_q;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end
    else
    begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;
endmodule

// ---- src/bcr_bank.sv ----
// board control register bank behind one local-bus chip select
// ************************************************************
// How it works
// - decode byte offsets only inside chip select
// - board id read-only fixed code
// - board version code, unused revision field
// - logic version major and minor, read-only
// - bit 1 shows live processor idle
// - bit 3 mirrors bridge mode switch
// - bits 4-5 route event button
// - bit 6 set turns pass lamp off
// - bit 7 set turns fail lamp off
// - map ends 0x3f, reserved offsets no function
// ************************************************************
`timescale 1ns/1ns
`include "bcr_consts.svh"
module bcr_bank
  import bcr_pkg::*;
#(
  parameter int        ADDR_W        = 6,
  parameter bcr_byte_t BOARD_ID      = 8'h5a, // arbitrary value
  parameter logic [3:0] BOARD_VER    = 4'h1,  // arbitrary value
  parameter logic [3:0] BOARD_REV    = 4'h0,
  parameter logic [3:0] LOGIC_MAJOR  = 4'h1,  // arbitrary value
  parameter logic [3:0] LOGIC_MINOR  = 4'h0
)(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // host local bus, one chip select
  input  wire logic              host_chip_select_three_n,
  input  wire logic              bus_we_n,
  input  wire logic              bus_oe_n,
  input  wire logic [ADDR_W-1:0] bus_addr,
  input  wire logic [7:0]        bus_wdata,
  output bcr_byte_t              bus_rdata,
  // board status inputs, asynchronous
  input  wire logic              processors_idle,
  input  wire logic              bridge_mode_switch,
  input  wire logic              event_button_n,
  input  wire logic [7:0]        power_status_in,
  input  wire logic [7:0]        clock_speed_switches_in,
  input  wire logic [7:0]        sequencer_status_in,
  // board control outputs
  output logic                   bridge_endpoint_select,
  output logic                   debugger_interrupt_n,
  output logic                   soft_reset_request_n,
  output logic                   user_debug_event_a_n,
  output logic                   user_debug_event_b_n,
  output logic                   pass_lamp_on,
  output logic                   fail_lamp_on,
  output bcr_byte_t              reset_control,
  output bcr_byte_t              sequencer_control,
  output bcr_byte_t              watchdog_setting,
  output bcr_byte_t              indicator_lamps
);
  // the decode and the synchroniser loop below are built for six address bits
  if (ADDR_W != 6)
  begin : g_bad_addr_w
    $error("bcr_bank serves a 64-byte window only");
  end

  // ************************************************************
  // input synchronisers
  // ************************************************************
  logic cs_s;
  logic we_s;
  logic oe_s;
  logic idle_s;
  logic mode_s;
  logic button_s;
  logic [7:0] power_s;
  logic [7:0] speed_s;
  logic [7:0] seqst_s;
  logic [5:0] addr_s;
  logic [7:0] wdata_s;

  // every pin passes two flops; an access costs three clocks in return
  bcr_sync2 u_cs   (.clk(clk), .rst(rst), .din(~host_chip_select_three_n), .dout(cs_s));
  bcr_sync2 u_we   (.clk(clk), .rst(rst), .din(~bus_we_n), .dout(we_s));
  bcr_sync2 u_oe   (.clk(clk), .rst(rst), .din(~bus_oe_n), .dout(oe_s));
  bcr_sync2 u_idle (.clk(clk), .rst(rst), .din(processors_idle), .dout(idle_s));
  bcr_sync2 u_mode (.clk(clk), .rst(rst), .din(bridge_mode_switch), .dout(mode_s));
  bcr_sync2 u_btn  (.clk(clk), .rst(rst), .din(~event_button_n), .dout(button_s));

  // address and data are held steady by the host while the strobe is active
  genvar g;
  generate
    for (g = 0; g < 8; g++)
    begin : g_sync
      bcr_sync2 u_pw (.clk(clk), .rst(rst), .din(power_status_in[g]), .dout(power_s[g]));
      bcr_sync2 u_sp (.clk(clk), .rst(rst), .din(clock_speed_switches_in[g]),
                      .dout(speed_s[g]));
      bcr_sync2 u_sq (.clk(clk), .rst(rst), .din(sequencer_status_in[g]), .dout(seqst_s[g]));
      bcr_sync2 u_wd (.clk(clk), .rst(rst), .din(bus_wdata[g]), .dout(wdata_s[g]));
    end
    for (g = 0; g < 6; g++)
    begin : g_async
      bcr_sync2 u_ad (.clk(clk), .rst(rst), .din(bus_addr[g]), .dout(addr_s[g]));
    end
  endgenerate

  // ************************************************************
  // write strobe: one pulse per chip-select write cycle
  // ************************************************************
  // a strobe held for many clocks writes once; the host drops it between writes
  logic wr_seen_q;
  wire  wr_req   = cs_s && we_s;
  wire  wr_pulse = wr_req && !wr_seen_q;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      wr_seen_q <= 1'b0;
    else
      wr_seen_q <= wr_req;
  end

  bcr_wr_if wr ();
  assign wr.we   = wr_pulse;
  assign wr.addr = addr_s;
  assign wr.data = wdata_s;

  // big-endian bit n lives at little-endian index 7-n
  function automatic int be(input int n);
    return 7 - n;
  endfunction

  // ************************************************************
  // general control/status: only bits 4-7 are stored
  // ************************************************************
  // the pass lamp starts dark and the fail lamp lit until self-test software clears them
  logic [1:0] route_q;
  logic       pass_off_q;
  logic       fail_off_q;
  wire        csr_hit = wr_pulse && (addr_s == `BCR_OFS_CTRL_STAT);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      route_q    <= 2'h0;
      pass_off_q <= `BCR_RST_PASS_OFF;
      fail_off_q <= `BCR_RST_FAIL_OFF;
    end
    else if (csr_hit)
    begin
      route_q    <= {wdata_s[be(`BCR_BIT_ROUTE_HI)], wdata_s[be(`BCR_BIT_ROUTE_LO)]};
      pass_off_q <= wdata_s[be(`BCR_BIT_PASS_OFF)];
      fail_off_q <= wdata_s[be(`BCR_BIT_FAIL_OFF)];
    end
  end

  // bits 0 and 2 are reserved and read as zero
  bcr_byte_t csr_val;
  always_comb
  begin
    csr_val = `BCR_RST_CTRL_STAT;
    csr_val[be(`BCR_BIT_IDLE)]     = idle_s;
    csr_val[be(`BCR_BIT_ENDPOINT)] = mode_s;
    csr_val[be(`BCR_BIT_ROUTE_HI)] = route_q[1];
    csr_val[be(`BCR_BIT_ROUTE_LO)] = route_q[0];
    csr_val[be(`BCR_BIT_PASS_OFF)] = pass_off_q;
    csr_val[be(`BCR_BIT_FAIL_OFF)] = fail_off_q;
  end

  // ************************************************************
  // plain storage registers
  // ************************************************************
  localparam int NST = 19;
  localparam logic [5:0] ST_OFS [NST] = '{
    `BCR_OFS_RESET_CTRL, `BCR_OFS_AUX_ONE, `BCR_OFS_AUX_TWO, `BCR_OFS_SEQ_CTRL,
    `BCR_OFS_SEQ_CFG0, `BCR_OFS_SEQ_CFG1, `BCR_OFS_CORE_VOLT, `BCR_OFS_BOOT_SET,
    `BCR_OFS_SPEED0, `BCR_OFS_SPEED1, `BCR_OFS_SPEED2, `BCR_OFS_SYSCLK0,
    `BCR_OFS_SYSCLK1, `BCR_OFS_SYSCLK2, `BCR_OFS_MEMCLK0, `BCR_OFS_MEMCLK1,
    `BCR_OFS_MEMCLK2, `BCR_OFS_WATCHDOG, `BCR_OFS_LAMPS};
  localparam bcr_byte_t ST_RST [NST] = '{
    `BCR_RST_RESET_CTRL, `BCR_RST_ZERO, `BCR_RST_ZERO, `BCR_RST_ZERO,
    `BCR_RST_ZERO, `BCR_RST_ZERO, `BCR_RST_VARIES, `BCR_RST_VARIES,
    `BCR_RST_VARIES, `BCR_RST_VARIES, `BCR_RST_VARIES, `BCR_RST_VARIES,
    `BCR_RST_VARIES, `BCR_RST_VARIES, `BCR_RST_VARIES, `BCR_RST_VARIES,
    `BCR_RST_VARIES, `BCR_RST_WATCHDOG, `BCR_RST_ZERO};

  bcr_byte_t st_val [NST];
  generate
    for (g = 0; g < NST; g++)
    begin : g_store
      bcr_store_reg #(.OFS(ST_OFS[g]), .RST_VALUE(ST_RST[g])) u_reg (
        .clk   (clk),
        .rst   (rst),
        .wr    (wr),
        .value (st_val[g])
      );
    end
  endgenerate

  // ************************************************************
  // read decode; reserved offsets read as zero
  // ************************************************************
  bcr_byte_t rd_mux;
  always_comb
  begin
    rd_mux = `BCR_RESERVED_READ;
    for (int i = 0; i < NST; i++)
    begin
      if (addr_s == ST_OFS[i])
        rd_mux = st_val[i];
    end
    unique case (addr_s)
      `BCR_OFS_BOARD_ID:   rd_mux = BOARD_ID;
      `BCR_OFS_BOARD_VER:  rd_mux = {BOARD_VER, BOARD_REV};
      `BCR_OFS_LOGIC_VER:  rd_mux = {LOGIC_MAJOR, LOGIC_MINOR};
      `BCR_OFS_CTRL_STAT:  rd_mux = csr_val;
      `BCR_OFS_POWER_STAT: rd_mux = power_s;
      `BCR_OFS_SPEED_SW:   rd_mux = speed_s;
      `BCR_OFS_SEQ_STAT:   rd_mux = seqst_s;
      default:             ;
    endcase
  end

  // read data is registered; zero when not selected for read
  // registering the mux keeps decode glitches off the bus at the cost of a clock
  bcr_byte_t rdata_q;
  wire       rd_en = cs_s && oe_s;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rdata_q <= 8'h00;
    else
      rdata_q <= rd_en ? rd_mux : 8'h00;
  end
  assign bus_rdata = rdata_q;

  // ************************************************************
  // board outputs
  // ************************************************************
  bcr_route_t route_e;
  assign route_e = bcr_route_t'(route_q);

  // registered so a route change never glitches an event line
  logic [3:0] evt_q;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      evt_q <= 4'h0;
    else
      evt_q <= button_s ? (4'h1 << route_e) : 4'h0;
  end

  assign debugger_interrupt_n   = ~evt_q[BCR_ROUTE_DEBUG_IRQ];
  assign soft_reset_request_n   = ~evt_q[BCR_ROUTE_SOFT_RESET];
  assign user_debug_event_a_n   = ~evt_q[BCR_ROUTE_USER_A];
  assign user_debug_event_b_n   = ~evt_q[BCR_ROUTE_USER_B];
  assign bridge_endpoint_select = mode_s;
  assign pass_lamp_on           = ~pass_off_q;
  assign fail_lamp_on           = ~fail_off_q;
  assign reset_control          = st_val[0];
  assign sequencer_control      = st_val[3];
  assign watchdog_setting       = st_val[17];
  assign indicator_lamps        = st_val[18];

  // ************************************************************
  // checks
  // ************************************************************
  sequence s_read_req;
    rd_en;
  endsequence

  sequence s_write_req;
    wr_pulse;
  endsequence

  sequence s_button;
    button_s;
  endsequence

  // register bus, event routing and lamps
  one_write_a: assert property (@(posedge clk) disable iff (rst)
    s_write_req |=> !wr_pulse)
    else $error("write strobe lasted more than one clock");
  id_read_a: assert property (@(posedge clk) disable iff (rst)
    s_read_req and addr_s == `BCR_OFS_BOARD_ID |=> bus_rdata == BOARD_ID)
    else $error("board id read wrong");
  bver_read_a: assert property (@(posedge clk) disable iff (rst)
    s_read_req and addr_s == `BCR_OFS_BOARD_VER |=> bus_rdata[7:4] == BOARD_VER)
    else $error("board version read wrong");
  lver_read_a: assert property (@(posedge clk) disable iff (rst)
    s_read_req and addr_s == `BCR_OFS_LOGIC_VER
    |=> bus_rdata == {LOGIC_MAJOR, LOGIC_MINOR})
    else $error("logic version read wrong");
  power_read_a: assert property (@(posedge clk) disable iff (rst)
    s_read_req and addr_s == `BCR_OFS_POWER_STAT |=> bus_rdata == $past(power_s))
    else $error("power status read wrong");
  speed_read_a: assert property (@(posedge clk) disable iff (rst)
    s_read_req and addr_s == `BCR_OFS_SPEED_SW |=> bus_rdata == $past(speed_s))
    else $error("speed switches read wrong");
  idle_bit_a: assert property (@(posedge clk) disable iff (rst)
    s_read_req and addr_s == `BCR_OFS_CTRL_STAT |=> bus_rdata[6] == $past(idle_s))
    else $error("idle bit does not follow processors");
  mode_bit_a: assert property (@(posedge clk) disable iff (rst)
    s_read_req and addr_s == `BCR_OFS_CTRL_STAT |=> bus_rdata[4] == $past(mode_s))
    else $error("mode bit does not follow switch");
  route_out_a: assert property (@(posedge clk) disable iff (rst)
    button_s && route_q == 2'h1 |=> !soft_reset_request_n && debugger_interrupt_n)
    else $error("event button routed wrongly");
  pass_lamp_a: assert property (@(posedge clk) disable iff (rst)
    csr_hit && wdata_s[1] |=> !pass_lamp_on)
    else $error("pass lamp not switched off");
  fail_lamp_a: assert property (@(posedge clk) disable iff (rst)
    csr_hit && !wdata_s[0] |=> fail_lamp_on)
    else $error("fail lamp not switched on");
  resv_read_a: assert property (@(posedge clk) disable iff (rst)
    s_read_req and addr_s == 6'h09 |=> bus_rdata == 8'h00)
    else $error("reserved offset not zero");
  resv_high_a: assert property (@(posedge clk) disable iff (rst)
    s_read_req and addr_s >= 6'h26 |=> bus_rdata == 8'h00)
    else $error("offset above the map not zero");

  // control/status fields, board outputs and idle read data
  route_store_a: assert property (@(posedge clk) disable iff (rst)
    s_write_req and addr_s == `BCR_OFS_CTRL_STAT |=> route_q == $past(wdata_s[3:2]))
    else $error("route field not stored");
  route_dbg_a: assert property (@(posedge clk) disable iff (rst)
    s_button and route_q == 2'h0 |=> !debugger_interrupt_n && soft_reset_request_n)
    else $error("button did not reach debugger interrupt");
  route_ua_a: assert property (@(posedge clk) disable iff (rst)
    s_button and route_q == 2'h2 |=> !user_debug_event_a_n && user_debug_event_b_n)
    else $error("button did not reach first user event");
  route_ub_a: assert property (@(posedge clk) disable iff (rst)
    s_button and route_q == 2'h3 |=> !user_debug_event_b_n && user_debug_event_a_n)
    else $error("button did not reach second user event");
  release_out_a: assert property (@(posedge clk) disable iff (rst)
    !button_s |=> debugger_interrupt_n && soft_reset_request_n &&
                  user_debug_event_a_n && user_debug_event_b_n)
    else $error("event line active without button");
  pass_on_a: assert property (@(posedge clk) disable iff (rst)
    csr_hit && !wdata_s[1] |=> pass_lamp_on)
    else $error("pass lamp not switched on");
  fail_off_a: assert property (@(posedge clk) disable iff (rst)
    csr_hit && wdata_s[0] |=> !fail_lamp_on)
    else $error("fail lamp not switched off");
  idle_bus_a: assert property (@(posedge clk) disable iff (rst)
    !rd_en |=> bus_rdata == 8'h00)
    else $error("read data outside chip select");
endmodule

// ---- sim/bcr_host_model.sv ----
// host local-bus controller model that drives the bank's chip select
`timescale 1ns/1ns
module bcr_host_model (
  // clock
  input  wire logic       clk,
  // local bus
  output logic            cs_n,
  output logic            we_n,
  output logic            oe_n,
  output logic [5:0]      addr,
  output logic [7:0]      wdata,
  input  wire logic [7:0] rdata
);
  initial
  begin
    cs_n = 1'b1;
    we_n = 1'b1;
    oe_n = 1'b1;
    addr = 6'h2a;
    wdata = 8'ha5;
  end

  // released lines show the inverse of the last value, so stale data never looks driven
  task automatic release_bus(input logic [5:0] a, input logic [7:0] d);
    cs_n <= 1'b1;
    we_n <= 1'b1;
    oe_n <= 1'b1;
    addr <= ~a;
    wdata <= ~d;
    repeat (3) @(posedge clk);
  endtask

  // one register per write, with the chip select driven from sel
  task automatic write_reg(input logic [5:0] a, input logic [7:0] d, input logic sel);
    @(posedge clk);
    cs_n <= ~sel;
    we_n <= 1'b0;
    addr <= a;
    wdata <= d;
    repeat (4) @(posedge clk);
    release_bus(a, d);
  endtask

  task automatic read_reg(input logic [5:0] a, output logic [7:0] d);
    @(posedge clk);
    cs_n <= 1'b0;
    oe_n <= 1'b0;
    addr <= a;
    repeat (4) @(posedge clk);
    d = rdata;
    release_bus(a, wdata);
  endtask
endmodule

// ---- sim/bcr_bank_test.sv ----
// self-checking bench for the board control register bank
`timescale 1ns/1ns
module bcr_bank_test;
  import bcr_pkg::*;
  localparam bcr_byte_t  ID_V  = 8'h3c; // arbitrary value
  localparam logic [3:0] VER_V = 4'h6;  // arbitrary value
  localparam logic [3:0] MAJ_V = 4'h2;  // arbitrary value
  logic       clk, rst, cs_n, we_n, oe_n, idle, mode, btn_n, ep;
  logic [5:0] addr;
  logic [7:0] wdata, pwr, spd, seq;
  bcr_byte_t  rdata, rst_ctl, seq_ctl, wdog, lamps;
  logic [3:0] ev_n;
  logic       pass_on, fail_on;
  int         n_fail, num_checks, cyc;

  bcr_host_model host (.clk(clk), .cs_n(cs_n), .we_n(we_n), .oe_n(oe_n), .addr(addr),
                       .wdata(wdata), .rdata(rdata));
  bcr_bank #(.BOARD_ID(ID_V), .BOARD_VER(VER_V), .BOARD_REV(4'h0), .LOGIC_MAJOR(MAJ_V),
             .LOGIC_MINOR(4'h0)) dut (
    .clk(clk), .rst(rst), .host_chip_select_three_n(cs_n), .bus_we_n(we_n),
    .bus_oe_n(oe_n), .bus_addr(addr), .bus_wdata(wdata), .bus_rdata(rdata),
    .processors_idle(idle), .bridge_mode_switch(mode), .event_button_n(btn_n),
    .power_status_in(pwr), .clock_speed_switches_in(spd), .sequencer_status_in(seq),
    .bridge_endpoint_select(ep), .debugger_interrupt_n(ev_n[0]),
    .soft_reset_request_n(ev_n[1]), .user_debug_event_a_n(ev_n[2]),
    .user_debug_event_b_n(ev_n[3]), .pass_lamp_on(pass_on), .fail_lamp_on(fail_on),
    .reset_control(rst_ctl), .sequencer_control(seq_ctl), .watchdog_setting(wdog),
    .indicator_lamps(lamps));

  // ************************************************************
  // checking and closing
  // ************************************************************
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk1(input string what, input logic exp, input logic got);
    chk8(what, {7'h0, exp}, {7'h0, got});
  endtask

  task automatic rd_chk(input string what, input logic [5:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.read_reg(a, d);
    chk8(what, exp, d);
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset();
    rd_chk("reset_control", 6'h04, 8'h8f);
    rd_chk("watchdog_setting", 6'h24, 8'h7f);
    rd_chk("indicator_lamps", 6'h25, 8'h00);
    rd_chk("auxiliary_scratch_one", 6'h06, 8'h00);
    rd_chk("general_control_status", 6'h03, 8'h02);
    chk1("pass_lamp_on", 1'b0, pass_on);
    chk1("fail_lamp_on", 1'b1, fail_on);
    chk8("event outputs", 8'h0f, {4'h0, ev_n});
  endtask

  // read-only identity bytes must survive writes: the id its complement, the version bytes 0xff
  task automatic t_ident();
    host.write_reg(6'h00, ~ID_V, 1'b1);
    host.write_reg(6'h01, 8'hff, 1'b1);
    host.write_reg(6'h02, 8'hff, 1'b1);
    rd_chk("board_identification", 6'h00, ID_V);
    rd_chk("board_version", 6'h01, {VER_V, 4'h0});
    rd_chk("logic_image_version", 6'h02, {MAJ_V, 4'h0});
  endtask

  // all writes first, then all reads, so an offset that aliases another shows up
  task automatic t_rw();
    logic [5:0] ofs [19] = '{6'h04, 6'h06, 6'h08, 6'h10, 6'h12, 6'h13, 6'h14, 6'h16,
                            6'h17, 6'h18, 6'h19, 6'h1c, 6'h1d, 6'h1e, 6'h1f, 6'h20,
                            6'h21, 6'h24, 6'h25};
    for (int i = 0; i < 19; i++)
      host.write_reg(ofs[i], {i[3:0], ~i[3:0]}, 1'b1);
    for (int i = 0; i < 19; i++)
      rd_chk("storage register", ofs[i], {i[3:0], ~i[3:0]});
    chk8("reset_control", 8'h0f, rst_ctl);
    chk8("sequencer_control", 8'h3c, seq_ctl);
    chk8("watchdog_setting", 8'h1e, wdog);
    chk8("indicator_lamps", 8'h2d, lamps);
  endtask

  task automatic t_reserved();
    logic [5:0] ofs [5] = '{6'h09, 6'h15, 6'h1a, 6'h22, 6'h3f};
    host.write_reg(6'h06, 8'h33, 1'b1);
    host.write_reg(6'h06, 8'hcc, 1'b0);
    rd_chk("unselected write", 6'h06, 8'h33);
    for (int i = 0; i < 5; i++)
    begin
      host.write_reg(ofs[i], 8'hff, 1'b1);
      rd_chk("reserved offset", ofs[i], 8'h00);
    end
  endtask

  task automatic t_status();
    @(posedge clk);
    idle <= 1'b1;
    pwr <= 8'h81;
    spd <= 8'h42;
    seq <= 8'h24;
    rd_chk("idle bit", 6'h03, 8'h42);
    rd_chk("power_status", 6'h05, 8'h81);
    rd_chk("clock_speed_switches", 6'h07, 8'h42);
    rd_chk("sequencer_status", 6'h11, 8'h24);
    @(posedge clk);
    idle <= 1'b0;
    mode <= 1'b1;
    rd_chk("endpoint bit", 6'h03, 8'h12);
    chk1("bridge_endpoint_select", 1'b1, ep);
  endtask

  task automatic t_route();
    for (int i = 0; i < 4; i++)
    begin
      host.write_reg(6'h03, {4'h0, i[1:0], 2'b00}, 1'b1);
      rd_chk("route field", 6'h03, {4'h1, i[1:0], 2'b00});
      btn_n <= 1'b0;
      repeat (5) @(posedge clk);
      chk8("routed event", {4'h0, 4'hf & ~(4'h1 << i)}, {4'h0, ev_n});
      btn_n <= 1'b1;
      repeat (5) @(posedge clk);
      chk8("released event", 8'h0f, {4'h0, ev_n});
    end
  endtask

  task automatic t_lamps();
    for (int i = 3; i >= 0; i--)
    begin
      host.write_reg(6'h03, {6'h0, i[1:0]}, 1'b1);
      chk1("pass_lamp_on", ~i[1], pass_on);
      chk1("fail_lamp_on", ~i[0], fail_on);
    end
  endtask

  // ************************************************************
  // clock, reset and main sequence
  // ************************************************************
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // the whole run needs about 700 cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      stop_test();
    end
  end

  initial
  begin
    rst = 1'b1;
    idle = 1'b0;
    mode = 1'b0;
    btn_n = 1'b1;
    pwr = 8'h00;
    spd = 8'h00;
    seq = 8'h00;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    t_reset();
    t_ident();
    t_rw();
    t_reserved();
    t_status();
    t_route();
    t_lamps();
    stop_test();
  end
endmodule
